// >>> ahr_pkg.sv
/*
  package for the alarm hysteresis relay block: register offsets, field
  layouts and sizes shared by the register slave and the
  alarm evaluation cell.
  assumes: a single 20 mhz clock domain, axi4-lite 32-bit data.
*/
package ahr_pkg;
  localparam int unsigned AHR_NUM_ALARMS = 8;   // alarm slots
  localparam int unsigned AHR_NUM_RELAYS = 8;   // two internal plus module
  localparam int unsigned AHR_NUM_CHANS  = 8;   // monitored channels
  localparam int unsigned AHR_VAL_W      = 16;  // signed channel value width
  localparam int unsigned AHR_CH_W       = 3;
  localparam int unsigned AHR_RLY_W      = 3;
  localparam int unsigned AHR_ADDR_W     = 8;
  // global registers
  localparam logic [7:0] AHR_OFS_CTRL    = 8'h00; // bit0 module fitted
  localparam logic [7:0] AHR_OFS_ACTIVE  = 8'h04; // active alarm list, ro
  localparam logic [7:0] AHR_OFS_RELAY   = 8'h08; // relay outputs, ro
  localparam logic [7:0] AHR_OFS_FLASH   = 8'h0c; // per channel flash, ro
  localparam logic [7:0] AHR_OFS_IRQ_ST  = 8'h10; // sticky status, ro
  localparam logic [7:0] AHR_OFS_IRQ_EN  = 8'h14; // interrupt enable
  localparam logic [7:0] AHR_OFS_IRQ_CLR = 8'h18; // write one to clear
  localparam logic [7:0] AHR_OFS_SAMPLE  = 8'h1c; // sample write, wo
  localparam logic [7:0] AHR_OFS_DISMISS = 8'h20; // dismiss flags
  // per alarm: config at 0x40 + 8*n, limits at 0x44 + 8*n
  localparam logic [7:0] AHR_OFS_ACFG    = 8'h40;
  localparam logic [7:0] AHR_OFS_ALIM    = 8'h44;
  localparam int unsigned AHR_SLOT_SH    = 3;     // 8 bytes per alarm
  // config fields
  localparam int unsigned AHR_CFG_EN     = 0;
  localparam int unsigned AHR_CFG_DOWN   = 1;
  localparam int unsigned AHR_CFG_CH_LO  = 4;
  localparam int unsigned AHR_CFG_RLY_LO = 8;
  // limits fields: threshold low half, hysteresis high half
  localparam int unsigned AHR_LIM_HYS_LO = 16;
  // sample write fields: value low half, channel at bit 16
  localparam int unsigned AHR_SMP_CH_LO  = 16;
  localparam int unsigned AHR_CTRL_MOD   = 0;
  localparam logic [7:0]  AHR_INT_RELAYS = 8'h03; // relays h and i only
  localparam logic [1:0]  AHR_RESP_OKAY  = 2'b00;
  localparam logic [1:0]  AHR_RESP_SLVERR = 2'b10;
endpackage

// >>> ahr_alarm_cell.sv
/*
  one alarm slot: compares the channel value against its threshold with
  hysteresis and holds the alarm state between the two levels.
  assumes: sample strobe from the same clock, signed values.
*/
`timescale 1ns/1ps
module ahr_alarm_cell
  import ahr_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        arst_n,
  input  wire logic                        enable,      // slot in use
  input  wire logic                        dir_down,    // lower limit
  input  wire logic signed [AHR_VAL_W-1:0] threshold,
  input  wire logic        [AHR_VAL_W-1:0] hysteresis,
  input  wire logic                        sample_stb,  // new sample here
  input  wire logic signed [AHR_VAL_W-1:0] sample_val,
  output logic                             active
);
  logic                     active_q;
  logic                     active_d;
  logic signed [AHR_VAL_W+1:0] val_x;   // widened to avoid overflow
  logic signed [AHR_VAL_W+1:0] thr_x;
  logic signed [AHR_VAL_W+1:0] rel_up;  // up release level
  logic signed [AHR_VAL_W+1:0] rel_dn;  // down release level
  logic                     set_up;
  logic                     clr_up;
  logic                     set_dn;
  logic                     clr_dn;

  assign val_x  = (AHR_VAL_W+2)'(sample_val);
  assign thr_x  = (AHR_VAL_W+2)'(threshold);
  assign rel_up = thr_x - $signed({2'b00, hysteresis});
  assign rel_dn = thr_x + $signed({2'b00, hysteresis});
  assign set_up = val_x > thr_x;
  assign clr_up = val_x < rel_up;
  assign set_dn = val_x < thr_x;
  assign clr_dn = val_x > rel_dn;

  // next state: set, release, or hold inside the band
  always_comb begin
    active_d = active_q;
    if (!enable) begin
      active_d = 1'b0;
    end else if (sample_stb) begin
      if (dir_down) begin
        if (set_dn) active_d = 1'b1;
        else if (clr_dn) active_d = 1'b0;
      end else begin
        if (set_up) active_d = 1'b1;
        else if (clr_up) active_d = 1'b0;
      end
    end
  end

  // alarm state register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) active_q <= 1'b0;
    else active_q <= active_d;
  end

  assign active = active_q;
endmodule

// >>> ahr_top.sv
/*
  alarm hysteresis relay block: eight alarm slots with threshold and
  hysteresis, relay routing with dismiss, flash per channel, active
  alarm list, interrupt on alarm set, axi4-lite register slave.
  assumes: channel samples arrive as register writes or on the sample
  port from logic on the same clock; relay outputs drive relay drivers.
*/
// Function
// - up alarm sets above threshold
// - up alarm clears below threshold minus hysteresis
// - down alarm sets below threshold
// - down alarm clears above threshold plus hysteresis
// - each alarm selects one relay output
// - active alarm flashes its channel value
// - active alarm energises its assigned relay
// - active list drops alarms once inactive
// - dismissed alarm no longer drives relay
// - up to eight relays with module fitted
`timescale 1ns/1ps
module ahr_top
  import ahr_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        arst_n,
  // sample port from the acquisition logic
  input  wire logic                        smp_valid,
  input  wire logic        [AHR_CH_W-1:0]  smp_chan,
  input  wire logic signed [AHR_VAL_W-1:0] smp_value,
  // axi4-lite slave
  input  wire logic [AHR_ADDR_W-1:0]       s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [AHR_ADDR_W-1:0]       s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // outputs
  output logic [AHR_NUM_RELAYS-1:0]        relay_out,   // relay coils
  output logic [AHR_NUM_CHANS-1:0]         flash_out,   // value flashing
  output logic                             irq
);
  localparam int N = AHR_NUM_ALARMS;

  // register state
  logic [N-1:0][15:0]        cfg_q;      // per alarm config
  logic [N-1:0][31:0]        lim_q;      // per alarm limits
  logic                      modfit_q;   // relay module fitted
  logic [N-1:0]              dismiss_q;  // dismiss flags
  logic [N-1:0]              irq_st_q;   // sticky alarm-set events
  logic [N-1:0]              irq_en_q;
  logic [N-1:0]              act_prev_q; // for rising edge events
  logic [AHR_NUM_RELAYS-1:0] relay_q;
  logic [AHR_NUM_CHANS-1:0]  flash_q;
  logic [N-1:0]              active;     // from the cells

  // sample selection: register write or port, port wins a tie
  logic                        reg_smp_stb;
  logic                        smp_stb;
  logic [AHR_CH_W-1:0]         smp_ch;
  logic signed [AHR_VAL_W-1:0] smp_v;

  // write channel capture, address and data may come in either order
  logic                  aw_have_q;
  logic                  w_have_q;
  logic [AHR_ADDR_W-1:0] aw_q;
  logic [31:0]           wd_q;
  logic [3:0]            ws_q;
  logic                  wr_go;
  logic [AHR_ADDR_W-1:0] wa;
  logic [31:0]           wmask;
  logic [31:0]           wdm;       // write data masked by byte enable

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign wr_go         = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wa            = aw_q;
  assign wmask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};

  // write decode
  logic         wa_slot;        // address inside alarm slot window
  logic [2:0]   wa_idx;
  logic         wa_cfg;
  logic         wa_lim;
  logic         wa_hit;
  // slot window is 0x40..0x7f only, so higher words do not alias slots
  assign wa_slot = wa[AHR_ADDR_W-1:AHR_SLOT_SH+3]
                   == AHR_OFS_ACFG[AHR_ADDR_W-1:AHR_SLOT_SH+3];
  assign wa_idx  = wa[AHR_SLOT_SH+2:AHR_SLOT_SH];
  assign wa_cfg  = wa_slot && wa[2] == AHR_OFS_ACFG[2];
  assign wa_lim  = wa_slot && wa[2] == AHR_OFS_ALIM[2];
  assign wa_hit  = (wa[1:0] == 2'b00) && (wa_slot
                 || wa == AHR_OFS_CTRL || wa == AHR_OFS_IRQ_EN
                 || wa == AHR_OFS_IRQ_CLR || wa == AHR_OFS_SAMPLE
                 || wa == AHR_OFS_DISMISS || wa == AHR_OFS_ACTIVE
                 || wa == AHR_OFS_RELAY || wa == AHR_OFS_FLASH
                 || wa == AHR_OFS_IRQ_ST);

  assign reg_smp_stb = wr_go && wa == AHR_OFS_SAMPLE;
  assign smp_stb = smp_valid || reg_smp_stb;
  assign smp_ch  = smp_valid ? smp_chan
                 : wd_q[AHR_SMP_CH_LO +: AHR_CH_W];
  assign smp_v   = smp_valid ? smp_value : wd_q[AHR_VAL_W-1:0];

  // capture of write address and write data
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_q      <= '0;
      wd_q      <= '0;
      ws_q      <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_q      <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wd_q     <= s_axi_wdata;
        ws_q     <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AHR_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wa_hit ? AHR_RESP_OKAY : AHR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // per alarm configuration, merged under byte enables
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= '0;
      lim_q <= '0;
    end else if (wr_go) begin
      if (wa_cfg)
        cfg_q[wa_idx] <= 16'((wd_q & wmask) | ({16'h0000, cfg_q[wa_idx]}
                         & ~wmask));
      if (wa_lim)
        lim_q[wa_idx] <= (wd_q & wmask) | (lim_q[wa_idx] & ~wmask);
    end
  end

  // global control, dismiss flags and interrupt enable
  assign wdm = wd_q & wmask;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      modfit_q  <= 1'b0;
      dismiss_q <= '0;
      irq_en_q  <= '0;
    end else begin
      if (wr_go && wa == AHR_OFS_CTRL && ws_q[0])
        modfit_q <= wd_q[AHR_CTRL_MOD];
      if (wr_go && wa == AHR_OFS_IRQ_EN && ws_q[0])
        irq_en_q <= wd_q[N-1:0];
      // a dismiss lapses once its alarm goes inactive
      if (wr_go && wa == AHR_OFS_DISMISS && ws_q[0])
        dismiss_q <= wd_q[N-1:0] & active;
      else
        dismiss_q <= dismiss_q & active;
    end
  end

  // alarm slots
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_alarm
      ahr_alarm_cell u_cell (
        .clock      (clock),
        .arst_n     (arst_n),
        .enable     (cfg_q[g][AHR_CFG_EN]),
        .dir_down   (cfg_q[g][AHR_CFG_DOWN]),
        .threshold  (lim_q[g][AHR_VAL_W-1:0]),
        .hysteresis (lim_q[g][AHR_LIM_HYS_LO +: AHR_VAL_W]),
        .sample_stb (smp_stb && smp_ch ==
                     cfg_q[g][AHR_CFG_CH_LO +: AHR_CH_W]),
        .sample_val (smp_v),
        .active     (active[g])
      );
    end
  endgenerate

  // relay and flash mapping
  logic [AHR_NUM_RELAYS-1:0] relay_d;
  logic [AHR_NUM_RELAYS-1:0] relay_ok;  // relays present
  logic [AHR_NUM_CHANS-1:0]  flash_d;
  assign relay_ok = modfit_q ? '1 : AHR_INT_RELAYS;
  always_comb begin
    relay_d = '0;
    flash_d = '0;
    for (int i = 0; i < N; i++) begin
      if (active[i])
        flash_d[cfg_q[i][AHR_CFG_CH_LO +: AHR_CH_W]] = 1'b1;
      if (active[i] && !dismiss_q[i])
        relay_d[cfg_q[i][AHR_CFG_RLY_LO +: AHR_RLY_W]] = 1'b1;
    end
    relay_d = relay_d & relay_ok;
  end

  // registered outputs and interrupt events
  logic [N-1:0] irq_clr;
  logic [N-1:0] irq_set;
  assign irq_clr = (wr_go && wa == AHR_OFS_IRQ_CLR && ws_q[0])
                 ? wd_q[N-1:0] : '0;
  assign irq_set = active & ~act_prev_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      relay_q    <= '0;
      flash_q    <= '0;
      act_prev_q <= '0;
      irq_st_q   <= '0;
    end else begin
      relay_q    <= relay_d;
      flash_q    <= flash_d;
      act_prev_q <= active;
      irq_st_q   <= (irq_st_q & ~irq_clr) | irq_set;  // set wins
    end
  end
  assign relay_out = relay_q;
  assign flash_out = flash_q;
  assign irq       = |(irq_st_q & irq_en_q);

  // read channel
  logic [31:0] rd_d;
  logic        rd_hit;
  logic [2:0]  ra_idx;
  logic        ra_slot;
  assign ra_idx  = s_axi_araddr[AHR_SLOT_SH+2:AHR_SLOT_SH];
  assign ra_slot = s_axi_araddr[AHR_ADDR_W-1:AHR_SLOT_SH+3]
                   == AHR_OFS_ACFG[AHR_ADDR_W-1:AHR_SLOT_SH+3];
  assign s_axi_arready = !s_axi_rvalid;
  always_comb begin
    rd_d   = '0;
    rd_hit = s_axi_araddr[1:0] == 2'b00;
    if (ra_slot && s_axi_araddr[2] == AHR_OFS_ACFG[2])
      rd_d = {16'h0000, cfg_q[ra_idx]};
    else if (ra_slot)
      rd_d = lim_q[ra_idx];
    else begin
      unique case (s_axi_araddr)
        AHR_OFS_CTRL:    rd_d = {31'h0, modfit_q};
        AHR_OFS_ACTIVE:  rd_d = {24'h0, active};
        AHR_OFS_RELAY:   rd_d = {24'h0, relay_q};
        AHR_OFS_FLASH:   rd_d = {24'h0, flash_q};
        AHR_OFS_IRQ_ST:  rd_d = {24'h0, irq_st_q};
        AHR_OFS_IRQ_EN:  rd_d = {24'h0, irq_en_q};
        AHR_OFS_DISMISS: rd_d = {24'h0, dismiss_q};
        AHR_OFS_IRQ_CLR: rd_d = '0;   // write only
        AHR_OFS_SAMPLE:  rd_d = '0;   // write only
        default:         rd_hit = 1'b0;
      endcase
    end
  end

  // read data register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= AHR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_d;
      s_axi_rresp  <= rd_hit ? AHR_RESP_OKAY : AHR_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// >>> ahr_top_sva.sv
/*
  port checker for the alarm relay block: output quiet rules, relay and
  flash relation, register bus answers and refusals.
  assumes: bound to ahr_top, one clock domain, reset active low.
*/
`timescale 1ns/1ps
module ahr_top_sva
  import ahr_pkg::*;
(
  input wire logic                      clock,
  input wire logic                      arst_n,
  input wire logic                      smp_valid,
  input wire logic                      s_axi_awvalid,
  input wire logic                      s_axi_awready,
  input wire logic                      s_axi_wvalid,
  input wire logic                      s_axi_wready,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_bready,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic                      s_axi_rvalid,
  input wire logic                      s_axi_rready,
  input wire logic [AHR_NUM_RELAYS-1:0] relay_out,
  input wire logic [AHR_NUM_CHANS-1:0]  flash_out
);
  logic [3:0] ev_q;  // recent samples or register writes
  wire        ev = smp_valid | (s_axi_wvalid & s_axi_wready) | s_axi_bvalid;
  // outputs may only move a few cycles after a sample or a write
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) ev_q <= 4'h0;
    else ev_q <= {ev_q[2:0], ev};
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_relay_quiet: assert property (!$stable(relay_out) |-> |ev_q)
    else $error("relay output moved with no sample or write");
  a_flash_quiet: assert property (!$stable(flash_out) |-> |ev_q)
    else $error("flash output moved with no sample or write");
  a_relay_flash: assert property (|relay_out |-> |flash_out)
    else $error("relay energised while no channel flashes");
  // both halves held one edge, bvalid launched the next, seen one later
  a_b_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_b_refuse: assert property (s_axi_bvalid |-> !s_axi_awready
    && !s_axi_wready)
    else $error("write taken while response pending");
  a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while response pending");
endmodule
bind ahr_top ahr_top_sva u_sva (.*);

// >>> ahr_alarm_unit.sv
/*
  external sound or light alarm unit wired to the relay contacts.
  assumes: contacts sampled on the block clock, one lamp per relay.
*/
`timescale 1ns/1ps
module ahr_alarm_unit
(
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic [7:0] relay_in,  // relay contacts
  output logic      [7:0] sounding   // lamp or horn per relay
);
  // unit signals one clock after its contact closes
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) sounding <= 8'h00;
    else sounding <= relay_in;
  end
endmodule

// >>> ahr_top_tb_top.sv
/*
  self-checking bench for the alarm relay block: corner and random
  samples on port and register path, relay routing, dismiss, interrupt.
  assumes: 20 mhz clock, axi4-lite master in this bench.
*/
`timescale 1ns/1ps
module ahr_top_tb_top
  import ahr_pkg::*;
;
  logic        clock, arst_n, smp_valid, s_axi_awvalid, s_axi_wvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_rready, irq, mod_m;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [2:0]  smp_chan;                 // sample channel
  logic [15:0] smp_value;                // sample value
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs_q;
  logic [7:0]  relay_out, flash_out, sounding, act_m, dis_m;
  int          error_cnt, tests_run, seed, c;
  int          thr_m[3] = '{100, -50, 0};  // alarm model table
  int          hys_m[3] = '{10, 20, 0};
  int          ch_m[3]  = '{1, 2, 3};
  int          rly_m[3] = '{0, 1, 5};
  logic        dn_m[3]  = '{1'b0, 1'b1, 1'b0};
  ahr_top uut (.*);
  ahr_alarm_unit u_unit (.clock, .arst_n, .relay_in(relay_out), .sounding);
  // free running clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one axi4-lite write or read, waits bounded
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    int   n;
    logic ta, tw, tr, tb;
    n = 0;
    tb = 1'b0;
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_araddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid  <= w;
    s_axi_bready  <= w;
    s_axi_arvalid <= !w;
    s_axi_rready  <= !w;
    while (!tb && n < 40) begin
      @(negedge clock);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tr = s_axi_arvalid & s_axi_arready;
      tb = (s_axi_bvalid & s_axi_bready) | (s_axi_rvalid & s_axi_rready);
      rd_q = s_axi_rdata;
      rs_q = w ? s_axi_bresp : s_axi_rresp;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
      if (tb) begin
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
      end
      n++;
    end
    if (!tb) begin
      error_cnt++;
      end_sim();
    end
  endtask
  // alarm state after one sample
  function automatic logic nxt(logic dn, int t, int h, int v, logic s);
    if (!dn) return v > t ? 1'b1 : (v < t - h ? 1'b0 : s);
    return v < t ? 1'b1 : (v > t + h ? 1'b0 : s);
  endfunction
  function automatic logic [7:0] e_rly;
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 3; i++)
      if (act_m[i] && !dis_m[i]) r[rly_m[i]] = 1'b1;
    return mod_m ? r : r & AHR_INT_RELAYS;
  endfunction
  function automatic logic [7:0] e_fl;
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 3; i++)
      if (act_m[i]) r[ch_m[i]] = 1'b1;
    return r;
  endfunction
  // compare outputs, unit and active list
  task automatic outs;
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk("relay", relay_out, e_rly());
    chk("flash", flash_out, e_fl());
    chk("unit", sounding, e_rly());
    bus(1'b0, AHR_OFS_ACTIVE, 32'h0);
    chk("active", rd_q, act_m);
  endtask
  // sample on the port or through the sample register
  task automatic smp(logic [2:0] ch, int v, logic r);
    if (r) bus(1'b1, AHR_OFS_SAMPLE, {13'h0, ch, v[15:0]});
    else begin
      @(posedge clock);
      smp_valid <= 1'b1;
      smp_chan  <= ch;
      smp_value <= v[15:0];
      @(posedge clock);
      smp_valid <= 1'b0;
    end
    for (int i = 0; i < 3; i++)
      if (ch_m[i] == ch) act_m[i] = nxt(dn_m[i], thr_m[i], hys_m[i], v, act_m[i]);
    dis_m = dis_m & act_m;
    outs();
  endtask
  // main sequence
  initial begin
    int cv[9] = '{100, 101, 95, 90, 89, -50, -51, -30, -29};
    {smp_valid, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, smp_chan, smp_value} = 21'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    {act_m, dis_m, mod_m} = 17'h0;
    {error_cnt, tests_run, seed} = {32'd0, 32'd0, 32'd32};
    arst_n = 1'b0;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    outs();
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 8'(AHR_OFS_ACFG + 8 * i), {21'h0, 3'(rly_m[i]), 1'b0,
          3'(ch_m[i]), 2'b0, dn_m[i], 1'b1});
      bus(1'b1, 8'(AHR_OFS_ALIM + 8 * i), {16'(hys_m[i]), 16'(thr_m[i])});
    end
    bus(1'b1, AHR_OFS_IRQ_EN, 32'hff);
    for (int k = 0; k < 9; k++) smp(k < 5 ? 3'd1 : 3'd2, cv[k], k[0]);
    bus(1'b0, AHR_OFS_IRQ_ST, 32'h0);
    chk("irq_st", rd_q, 32'h3);
    chk("irq", irq, 1'b1);
    bus(1'b1, AHR_OFS_IRQ_EN, 32'h0);
    chk("irq_mask", irq, 1'b0);
    bus(1'b1, AHR_OFS_IRQ_EN, 32'hff);
    bus(1'b1, AHR_OFS_IRQ_CLR, 32'hff);
    chk("irq_clr", irq, 1'b0);
    smp(3'd3, 5, 1'b0);
    bus(1'b1, AHR_OFS_CTRL, 32'h1);
    mod_m = 1'b1;
    outs();
    bus(1'b1, AHR_OFS_DISMISS, 32'h4);
    dis_m = 8'h04 & act_m;
    outs();
    bus(1'b0, AHR_OFS_DISMISS, 32'h0);
    chk("dismiss", rd_q, 32'h4);
    smp(3'd3, -1, 1'b1);
    bus(1'b0, AHR_OFS_DISMISS, 32'h0);
    chk("dismiss_drop", rd_q, 32'h0);
    bus(1'b0, 8'h24, 32'h0);
    chk("rresp", rs_q, AHR_RESP_SLVERR);
    bus(1'b1, 8'h24, 32'h0);
    chk("bresp", rs_q, AHR_RESP_SLVERR);
    bus(1'b0, 8'h80, 32'h0);
    chk("rresp_hi", rs_q, AHR_RESP_SLVERR);
    repeat (150) begin
      c = $random(seed) & 3;
      smp(c == 0 ? 3'd3 : 3'(c), $random(seed) % 160, 1'($random(seed)));
    end
    end_sim();
  end
endmodule
